// *** verilog/pcbs_top.sv ***
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps

module pcbs_top
   import pcbs_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b0
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // program fetch
   output logic [12:0] fetch_addr
);

   // ********************************************************
   // decode helpers
   // ********************************************************
   function automatic logic [12:0] wrap_fetch(input logic [12:0] pc_in);
      logic [12:0] res;
      res = 13'h0000;
      if (LARGE_VARIANT) begin
         res[PCBS_LARGE_PAGE_W-1:0] = pc_in[PCBS_LARGE_PAGE_W-1:0];
      end else begin
         res[PCBS_SMALL_PAGE_W-1:0] = pc_in[PCBS_SMALL_PAGE_W-1:0];
      end
      return res;
   endfunction : wrap_fetch

   // returns {hit, storage index}; the mirror folds onto bank 0 storage
   function automatic logic [8:0] map_file(input logic bank, input logic [6:0] fa);
      logic [7:0] full;
      logic hit;
      full = {bank, fa};
      hit = 1'b0;
      if (fa > PCBS_SFR_LAST) begin
         if (full >= PCBS_MIRROR_LOW) begin
            full = full - PCBS_MIRROR_SHIFT;
         end
         if (!full[7]) begin
            hit = LARGE_VARIANT ? (full[6:0] >= PCBS_RAM_LOW_LARGE)
                                : (full[6:0] >= PCBS_RAM_LOW_SMALL);
         end else begin
            hit = LARGE_VARIANT && full >= PCBS_B1_RAM_LOW && full <= PCBS_B1_RAM_HIGH;
         end
      end
      return {hit, full};
   endfunction : map_file

   // ********************************************************
   // state
   // ********************************************************
   pcbs_bus_t bus_state;
   pcbs_bus_t next_bus_state;
   pcbs_op_t op;
   pcbs_stack_if stk ();

   logic [12:0] pc;
   logic [12:0] next_pc;
   logic [4:0] pc_high_latch;
   logic bank_select_bit;
   logic upper_bank_bit;
   logic indirect_bank_bit;
   logic [6:0] file_addr;
   logic [7:0] general_ram [0:255];
   logic [8:0] file_map;
   logic file_hit;
   logic [7:0] file_rd;
   logic setup;
   logic wr_take;
   logic cmd_take;
   logic pcl_write;
   logic [10:0] operand;
   logic [31:0] rd_mux;
   logic rd_ok;

   assign setup = psel && !penable && bus_state == PCBS_BUS_IDLE;
   assign wr_take = psel && penable && pready && pwrite;
   assign cmd_take = wr_take && paddr == PCBS_OFF_COMMAND;
   assign pcl_write = wr_take && paddr == PCBS_OFF_PC_LOW;
   assign operand = pwdata[PCBS_OPERAND_LSB +: PCBS_OPERAND_W];
   assign op = pcbs_op_t'(pwdata[4:0]);
   assign file_map = map_file(bank_select_bit, file_addr);
   assign file_hit = file_map[8];
   assign file_rd = file_hit ? general_ram[file_map[7:0]] : 8'h00;

   // ********************************************************
   // apb slave: answer one cycle after setup, never waits
   // ********************************************************
   always_comb begin
      next_bus_state = PCBS_BUS_IDLE;
      case (bus_state)
         PCBS_BUS_IDLE: begin
            next_bus_state = setup ? PCBS_BUS_ANSWER : PCBS_BUS_IDLE;
         end
         PCBS_BUS_ANSWER: begin
            next_bus_state = PCBS_BUS_IDLE;
         end
         default: begin
            next_bus_state = PCBS_BUS_IDLE;
         end
      endcase
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      case (paddr)
         PCBS_OFF_PC_LOW: rd_mux[7:0] = pc[7:0];
         PCBS_OFF_HIGH_LATCH: rd_mux[4:0] = pc_high_latch;
         PCBS_OFF_STATUS: begin
            rd_mux[PCBS_BANK_SELECT_BIT] = bank_select_bit;
            rd_mux[PCBS_UPPER_BANK_BIT] = upper_bank_bit;
            rd_mux[PCBS_INDIRECT_BANK_BIT] = indirect_bank_bit;
         end
         PCBS_OFF_COMMAND: rd_mux = 32'h0000_0000;
         PCBS_OFF_PC_VIEW: begin
            rd_mux[12:0] = pc;
            rd_mux[PCBS_FETCH_LSB +: PCBS_PC_W] = fetch_addr;
         end
         PCBS_OFF_FILE_ADDR: rd_mux[6:0] = file_addr;
         PCBS_OFF_FILE_DATA: rd_mux[7:0] = file_rd;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= PCBS_BUS_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         bus_state <= next_bus_state;
         pready <= setup;
         if (setup) begin
            pslverr <= !rd_ok;
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // ********************************************************
   // software visible control registers
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_high_latch <= PCBS_LATCH_RESET;
      end else if (wr_take && paddr == PCBS_OFF_HIGH_LATCH) begin
         pc_high_latch <= pwdata[4:0];
      end
   end

   // only bits 5 to 7 are stored; reserved bits are dropped and read back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {indirect_bank_bit, upper_bank_bit, bank_select_bit} <= PCBS_STATUS_RESET;
      end else if (wr_take && paddr == PCBS_OFF_STATUS) begin
         bank_select_bit <= pwdata[PCBS_BANK_SELECT_BIT];
         upper_bank_bit <= pwdata[PCBS_UPPER_BANK_BIT];
         indirect_bank_bit <= pwdata[PCBS_INDIRECT_BANK_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_addr <= PCBS_FILE_ADDR_RESET;
      end else if (wr_take && paddr == PCBS_OFF_FILE_ADDR) begin
         file_addr <= pwdata[6:0];
      end
   end

   // ********************************************************
   // data memory
   // ********************************************************
   // writes to special registers or holes are dropped
   always_ff @(posedge pclk) begin
      if (wr_take && paddr == PCBS_OFF_FILE_DATA && file_hit) begin
         general_ram[file_map[7:0]] <= pwdata[7:0];
      end
   end

   // ********************************************************
   // program counter
   // ********************************************************
   always_comb begin
      next_pc = pc;
      stk.push = 1'b0;
      stk.pop = 1'b0;
      stk.push_data = pc + PCBS_PC_STEP;
      if (pcl_write) begin
         next_pc = {pc_high_latch, pwdata[7:0]};
      end else if (cmd_take) begin
         case (op)
            PCBS_OP_STEP: begin
               next_pc = pc + PCBS_PC_STEP;
            end
            PCBS_OP_GOTO: begin
               next_pc = {pc_high_latch[4:3], operand};
            end
            PCBS_OP_CALL: begin
               next_pc = {pc_high_latch[4:3], operand};
               stk.push = 1'b1;
            end
            PCBS_OP_RET: begin
               next_pc = stk.top;
               stk.pop = 1'b1;
            end
            PCBS_OP_INT: begin
               next_pc = PCBS_INT_VECTOR;
               stk.push = 1'b1;
               stk.push_data = pc;
            end
            default: begin
               next_pc = pc;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= PCBS_PC_RESET;
         fetch_addr <= PCBS_PC_RESET;
      end else begin
         pc <= next_pc;
         fetch_addr <= wrap_fetch(next_pc);
      end
   end

   pcbs_stack u_stack (
      .pclk(pclk),
      .presetn(presetn),
      .stk(stk)
   );

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_pcl_full_load: assert property (
      pcl_write |=> pc == {$past(pc_high_latch), $past(pwdata[7:0])})
      else $error("low byte write did not load upper bits from latch");

   a_jump_upper_bits: assert property (
      cmd_take && (op == PCBS_OP_GOTO || op == PCBS_OP_CALL)
      |=> pc[12:11] == $past(pc_high_latch[4:3]) && pc[10:0] == $past(operand))
      else $error("jump target bits wrong");

   a_int_vector: assert property (
      cmd_take && !pcl_write && op == PCBS_OP_INT |=> pc == PCBS_INT_VECTOR)
      else $error("interrupt entry missed vector");

   a_fetch_wrapped: assert property (
      fetch_addr == wrap_fetch(pc) && fetch_addr <= pc)
      else $error("fetch address not wrapped into implemented space");

   // bus spacing keeps a call and its return cycles apart, so check the push itself
   a_call_pushes: assert property (
      cmd_take && op == PCBS_OP_CALL |=> stk.top == $past(pc) + PCBS_PC_STEP)
      else $error("call did not push the return address");

   a_int_pushes: assert property (
      cmd_take && op == PCBS_OP_INT |=> stk.top == $past(pc))
      else $error("interrupt entry did not push the counter");

   a_mirror_fold: assert property (
      {bank_select_bit, file_addr} >= PCBS_MIRROR_LOW
      |-> file_hit && file_map[7:0] == {1'b0, file_addr})
      else $error("bank 1 top row not folded onto bank 0");

   a_special_area_dark: assert property (
      file_addr <= PCBS_SFR_LAST |-> !file_hit)
      else $error("special register area mapped to ram");

   a_error_with_ready: assert property (
      pslverr |-> pready)
      else $error("error flag without bus answer");

   a_latch_unmoved: assert property (
      cmd_take && (op == PCBS_OP_CALL || op == PCBS_OP_RET) |=> $stable(pc_high_latch))
      else $error("push or pop disturbed the latch");

   a_hole_reads_zero: assert property (
      setup && !pwrite && paddr == PCBS_OFF_FILE_DATA && !file_hit
      |=> pready && prdata == 32'h0000_0000)
      else $error("unimplemented data location read nonzero");

   a_step_no_carry_out: assert property (
      cmd_take && op == PCBS_OP_STEP |=> pc == $past(pc) + PCBS_PC_STEP)
      else $error("step did not advance counter by one");

   a_answer_timing: assert property (
      setup |=> pready ##1 !pready)
      else $error("bus answer not exactly one cycle after setup");

   c_pcl_write: cover property (pcl_write);
   c_call_then_ret: cover property (
      cmd_take && op == PCBS_OP_CALL ##[1:20] cmd_take && op == PCBS_OP_RET);
   c_mirror_hit: cover property (file_hit && bank_select_bit && file_addr >= 7'h70);
   c_bad_address: cover property (pslverr);
   c_step: cover property (cmd_take && op == PCBS_OP_STEP);

endmodule : pcbs_top

// *** pkg/pcbs_pkg.sv ***
package pcbs_pkg;

   // ********************************************************
   // apb register map (byte addresses)
   // ********************************************************
   localparam logic [7:0] PCBS_OFF_PC_LOW = 8'h00;
   localparam logic [7:0] PCBS_OFF_HIGH_LATCH = 8'h04;
   localparam logic [7:0] PCBS_OFF_STATUS = 8'h08;
   localparam logic [7:0] PCBS_OFF_COMMAND = 8'h0C;
   localparam logic [7:0] PCBS_OFF_PC_VIEW = 8'h10;
   localparam logic [7:0] PCBS_OFF_FILE_ADDR = 8'h14;
   localparam logic [7:0] PCBS_OFF_FILE_DATA = 8'h18;

   // ********************************************************
   // field layout and reset values
   // ********************************************************
   localparam int PCBS_PC_W = 13;
   localparam int PCBS_LATCH_W = 5;
   localparam int PCBS_OPERAND_W = 11;
   localparam int PCBS_OPERAND_LSB = 16;
   localparam int PCBS_FETCH_LSB = 16;
   localparam int PCBS_BANK_SELECT_BIT = 5;
   localparam int PCBS_UPPER_BANK_BIT = 6;
   localparam int PCBS_INDIRECT_BANK_BIT = 7;
   localparam int PCBS_SMALL_PAGE_W = 10;
   localparam int PCBS_LARGE_PAGE_W = 11;
   localparam logic [12:0] PCBS_PC_RESET = 13'h0000;
   localparam logic [12:0] PCBS_INT_VECTOR = 13'h0004;
   localparam logic [12:0] PCBS_PC_STEP = 13'h0001;
   localparam logic [4:0] PCBS_LATCH_RESET = 5'h00;
   localparam logic [2:0] PCBS_STATUS_RESET = 3'h0;
   localparam logic [6:0] PCBS_FILE_ADDR_RESET = 7'h00;

   // ********************************************************
   // data memory map
   // ********************************************************
   localparam logic [6:0] PCBS_SFR_LAST = 7'h1F;
   localparam logic [6:0] PCBS_RAM_LOW_SMALL = 7'h40;
   localparam logic [6:0] PCBS_RAM_LOW_LARGE = 7'h20;
   localparam logic [7:0] PCBS_B1_RAM_LOW = 8'hA0;
   localparam logic [7:0] PCBS_B1_RAM_HIGH = 8'hEF;
   localparam logic [7:0] PCBS_MIRROR_LOW = 8'hF0;
   localparam logic [7:0] PCBS_MIRROR_SHIFT = 8'h80;

   // ********************************************************
   // return stack
   // ********************************************************
   localparam int PCBS_STACK_DEPTH = 8;
   localparam int PCBS_STACK_PTR_W = 3;
   localparam logic [2:0] PCBS_PTR_STEP = 3'h1;
   localparam logic [2:0] PCBS_PTR_RESET = 3'h0;

   typedef enum logic [4:0] {
      PCBS_OP_STEP = 5'h01,
      PCBS_OP_GOTO = 5'h02,
      PCBS_OP_CALL = 5'h04,
      PCBS_OP_RET = 5'h08,
      PCBS_OP_INT = 5'h10
   } pcbs_op_t;

   typedef enum logic [1:0] {
      PCBS_BUS_IDLE = 2'h1,
      PCBS_BUS_ANSWER = 2'h2
   } pcbs_bus_t;

endpackage : pcbs_pkg

// *** pkg/pcbs_stack_if.sv ***
`timescale 1ns/10ps
interface pcbs_stack_if;
   logic push;
   logic pop;
   logic [12:0] push_data;
   logic [12:0] top;
   modport ctrl (output push, output pop, output push_data, input top);
   modport store (input push, input pop, input push_data, output top);
endinterface : pcbs_stack_if

// *** verilog/pcbs_stack.sv ***
`timescale 1ns/10ps
module pcbs_stack
   import pcbs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // stack port
   pcbs_stack_if.store stk
);

   logic [12:0] entry [0:PCBS_STACK_DEPTH-1];
   logic [2:0] ptr;

   // pointer wraps silently: ninth push lands on the first entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr <= PCBS_PTR_RESET;
      end else if (stk.push) begin
         ptr <= ptr + PCBS_PTR_STEP;
      end else if (stk.pop) begin
         ptr <= ptr - PCBS_PTR_STEP;
      end
   end

   always_ff @(posedge pclk) begin
      if (stk.push) begin
         entry[ptr] <= stk.push_data;
      end
   end

   assign stk.top = entry[ptr - PCBS_PTR_STEP];

endmodule : pcbs_stack

// *** dv/pcbs_top_tb.sv ***
`timescale 1ns/10ps
module pcbs_top_tb
   import pcbs_pkg::*;
;
   // ********************************************************
   // clock, reset and bus
   // ********************************************************
   logic pclk;
   logic presetn;
   logic [1:0] psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   wire [1:0][31:0] prdata;
   wire [1:0] pready;
   wire [1:0] pslverr;
   wire [1:0][12:0] fetch_addr;
   int n_fail;
   int comparisons;
   logic [31:0] rdv;
   logic errv;
   logic [6:0] places [7];
   logic [7:0] d;

   // index 0 is the small variant, index 1 the large one
   for (genvar v = 0; v < 2; v++) begin : g_var
      pcbs_top #(.LARGE_VARIANT(v == 1)) dut (
         .pclk(pclk),
         .presetn(presetn),
         .psel(psel[v]),
         .penable(penable),
         .pwrite(pwrite),
         .paddr(paddr),
         .pwdata(pwdata),
         .prdata(prdata[v]),
         .pready(pready[v]),
         .pslverr(pslverr[v]),
         .fetch_addr(fetch_addr[v])
      );
   end

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // ********************************************************
   // access tasks
   // ********************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one idle cycle after each transfer keeps every strobe to one write per step
   task automatic xfer(input int v, input logic wr, input logic [7:0] a, input logic [31:0] dv);
      int n;
      n = 0;
      psel <= (v == 1) ? 2'b10 : 2'b01;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready[v] !== 1'b1 && n < 20);
      rdv = prdata[v];
      errv = pslverr[v];
      if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
      psel <= 2'b00;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   task automatic wr(input int v, input logic [7:0] a, input logic [31:0] dv);
      xfer(v, 1'b1, a, dv);
   endtask : wr

   task automatic rd(input int v, input logic [7:0] a, input logic [31:0] exp);
      xfer(v, 1'b0, a, 32'h0000_0000);
      chk(rdv, exp);
   endtask : rd

   task automatic op(input int v, input logic [4:0] code, input logic [10:0] arg);
      wr(v, PCBS_OFF_COMMAND, {5'h00, arg, 11'h000, code});
   endtask : op

   // fetch must wrap inside the implemented program size
   task automatic pc_is(input int v, input logic [12:0] pc);
      logic [12:0] f;
      f = pc & ((v == 1) ? 13'h07FF : 13'h03FF);
      rd(v, PCBS_OFF_PC_VIEW, {3'h0, f, 3'h0, pc});
      chk({19'h0_0000, fetch_addr[v]}, {19'h0_0000, f});
   endtask : pc_is

   task automatic sel(input int v, input logic b, input logic [6:0] a);
      wr(v, PCBS_OFF_STATUS, {24'h00_0000, 2'b00, b, 5'h00});
      wr(v, PCBS_OFF_FILE_ADDR, {25'h000_0000, a});
   endtask : sel

   function automatic logic impl(input int v, input logic b, input logic [6:0] a);
      if (a < 7'h20) return 1'b0;
      if (!b) return (v == 1) || (a >= 7'h40);
      return (v == 1) || (a >= 7'h70);
   endfunction : impl

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge pclk);
      chk(32'h0000_0000, 32'h0000_0001);
      results();
   end

   // ********************************************************
   // tests
   // ********************************************************
   initial begin
      presetn = 1'b0;
      psel = 2'b00;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      places = '{7'h05, 7'h1F, 7'h20, 7'h3F, 7'h40, 7'h6F, 7'h7F};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int v = 0; v < 2; v++) begin
         pc_is(v, 13'h0000);
         wr(v, PCBS_OFF_HIGH_LATCH, 32'h0000_001E);
         wr(v, PCBS_OFF_PC_LOW, 32'h0000_003C);
         pc_is(v, 13'h1E3C);
         rd(v, PCBS_OFF_PC_LOW, 32'h0000_003C);
         wr(v, PCBS_OFF_PC_VIEW, 32'h0000_0000);
         pc_is(v, 13'h1E3C);
         op(v, PCBS_OP_GOTO, 11'h5A5);
         pc_is(v, 13'h1DA5);
         op(v, PCBS_OP_CALL, 11'h100);
         pc_is(v, 13'h1900);
         op(v, PCBS_OP_INT, 11'h000);
         pc_is(v, 13'h0004);
         op(v, PCBS_OP_RET, 11'h000);
         pc_is(v, 13'h1900);
         op(v, PCBS_OP_RET, 11'h000);
         pc_is(v, 13'h1DA6);
         rd(v, PCBS_OFF_HIGH_LATCH, 32'h0000_001E);
         // page crossing: the step carries, a low byte write never does
         wr(v, PCBS_OFF_HIGH_LATCH, 32'h0000_0001);
         wr(v, PCBS_OFF_PC_LOW, 32'h0000_00FF);
         pc_is(v, 13'h01FF);
         op(v, PCBS_OP_STEP, 11'h000);
         pc_is(v, 13'h0200);
         wr(v, PCBS_OFF_PC_LOW, 32'h0000_0000);
         pc_is(v, 13'h0100);
         wr(v, PCBS_OFF_HIGH_LATCH, 32'h0000_0002);
         wr(v, PCBS_OFF_PC_LOW, 32'h0000_0000);
         pc_is(v, 13'h0200);
         // nine calls: the last push lands on the slot of the first
         wr(v, PCBS_OFF_HIGH_LATCH, 32'h0000_0000);
         op(v, PCBS_OP_GOTO, 11'h000);
         for (int k = 0; k < 9; k++) op(v, PCBS_OP_CALL, 11'((k + 1) * 16));
         for (int k = 8; k >= 1; k--) begin
            op(v, PCBS_OP_RET, 11'h000);
            pc_is(v, 13'(k * 16 + 1));
         end
         op(v, PCBS_OP_RET, 11'h000);
         pc_is(v, 13'h0081);
         for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 7; i++) begin
               d = {b[0], places[i]} ^ 8'hA5;
               sel(v, b[0], places[i]);
               rd(v, PCBS_OFF_STATUS, {24'h00_0000, 2'b00, b[0], 5'h00});
               wr(v, PCBS_OFF_FILE_DATA, {24'h00_0000, d});
               rd(v, PCBS_OFF_FILE_DATA, impl(v, b[0], places[i]) ? {24'h0, d} : 32'h0);
            end
         end
         sel(v, 1'b0, 7'h40);
         rd(v, PCBS_OFF_FILE_DATA, 32'h0000_00E5);
         sel(v, 1'b0, 7'h7F);
         rd(v, PCBS_OFF_FILE_DATA, 32'h0000_005A);
         rd(v, 8'h1C, 32'h0000_0000);
         chk({31'h0000_0000, errv}, 32'h0000_0001);
      end
      // reset in mid-run must clear a counter that is far from zero
      wr(1, PCBS_OFF_HIGH_LATCH, 32'h0000_0003);
      wr(1, PCBS_OFF_PC_LOW, 32'h0000_0055);
      pc_is(1, 13'h0355);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      pc_is(1, 13'h0000);
      pc_is(0, 13'h0000);
      results();
   end
endmodule : pcbs_top_tb
